// file: sdp_pkg.sv
package sdp_pkg;

  // Command codes, read as {cs_n, ras_n, cas_n, we_n}.
  localparam logic [3:0] SDP_CMD_MODE  = 4'h0;
  localparam logic [3:0] SDP_CMD_REFR  = 4'h1;
  localparam logic [3:0] SDP_CMD_PRE   = 4'h2;
  localparam logic [3:0] SDP_CMD_ACT   = 4'h3;
  localparam logic [3:0] SDP_CMD_WRITE = 4'h4;
  localparam logic [3:0] SDP_CMD_READ  = 4'h5;
  localparam logic [3:0] SDP_CMD_BST   = 4'h6;

  // Address bus fields.
  localparam int SDP_PRE_ALL_BIT = 10;
  localparam int SDP_BL_LSB      = 0;
  localparam int SDP_CL_LSB      = 4;
  localparam logic [2:0] SDP_BL_FULL = 3'h7;
  localparam logic [2:0] SDP_CL3     = 3'h3;

  // Values after reset and the mode word that the host loads.
  localparam logic [12:0] SDP_MODE_RST  = 13'h0000;
  localparam logic [12:0] SDP_HOST_MODE = 13'h0020;

  // Column bits that index the small flip-flop array of the device end.
  localparam int SDP_MEM_COL_BITS = 2;

  // Host timing counts in core_clk cycles.
  localparam logic [3:0] SDP_INIT_CYC = 4'h8;
  localparam logic [3:0] SDP_RCD_CYC  = 4'h2;
  localparam logic [3:0] SDP_RP_CYC   = 4'h2;
  localparam logic [3:0] SDP_RD_TMO   = 4'h6;

  typedef enum logic [1:0] {
    SDP_RUN    = 2'b00,
    SDP_PD_PRE = 2'b01,
    SDP_PD_ACT = 2'b10,
    SDP_SELF   = 2'b11
  } sdp_pmode_t;

  typedef enum logic [3:0] {
    SDP_H_INIT  = 4'b0000,
    SDP_H_MODE  = 4'b0001,
    SDP_H_RECOV = 4'b0010,
    SDP_H_IDLE  = 4'b0011,
    SDP_H_PD    = 4'b0100,
    SDP_H_ACTW  = 4'b0101,
    SDP_H_RDW   = 4'b0110
  } sdp_hstate_t;

  // Column from the address bus, by data width.
  function automatic logic [11:0] sdp_col_of(input logic [12:0] a, input int dq_w);
    logic [11:0] c;
    c = {2'b00, a[9:0]};
    if (dq_w == 4) c = {a[12], a[11], a[9:0]};
    else if (dq_w == 8) c = {1'b0, a[11], a[9:0]};
    return c;
  endfunction

  // Address bus from a column and the auto precharge request.
  function automatic logic [12:0] sdp_addr_of(input logic [11:0] c, input int dq_w,
                                              input logic ap);
    logic [12:0] a;
    a = {(dq_w == 4) ? c[11] : 1'b0, (dq_w != 16) ? c[10] : 1'b0, ap, c[9:0]};
    return a;
  endfunction

endpackage

// file: sdp_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sdp_link_if #(
  parameter int DQ_W = 16,
  parameter int NL   = (DQ_W == 16) ? 2 : 1
);
  localparam int LW = DQ_W / NL;

  logic            cke;
  logic            cs_n;
  logic            ras_n;
  logic            cas_n;
  logic            we_n;
  logic [1:0]      ba;
  logic [12:0]     addr;
  logic            low_byte_mask;
  logic            high_byte_mask;
  logic [DQ_W-1:0] host_dq;
  logic            host_dq_oe_n;
  logic [DQ_W-1:0] dev_dq;
  logic [NL-1:0]   dev_dq_oe_n;
  logic [DQ_W-1:0] dq;

  // Wire level per lane; an undriven lane floats high as if pulled up.
  for (genvar g = 0; g < NL; g++) begin : g_lane
    assign dq[g*LW +: LW] = !dev_dq_oe_n[g] ? dev_dq[g*LW +: LW] :
                            !host_dq_oe_n ? host_dq[g*LW +: LW] : {LW{1'b1}};
  end

  modport host (output cke, cs_n, ras_n, cas_n, we_n, ba, addr,
                output low_byte_mask, high_byte_mask, host_dq, host_dq_oe_n,
                input dq, dev_dq_oe_n);
  modport dev  (input cke, cs_n, ras_n, cas_n, we_n, ba, addr,
                input low_byte_mask, high_byte_mask, dq,
                output dev_dq, dev_dq_oe_n);
endinterface
`default_nettype wire

// file: sdp_host.sv
`timescale 1ns/1ps
`default_nettype none
module sdp_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 8
) (
  input  wire logic         core_clk,  // System clock.
  input  wire logic         sys_rst,   // Synchronous reset, active high.
  input  wire logic         in_valid,  // Write side word valid.
  output logic              in_ready,  // Room for a word.
  input  wire logic [W-1:0] in_data,   // Write side word.
  output logic              out_valid, // Word available.
  input  wire logic         out_ready, // Reader takes the word.
  output logic [W-1:0]      out_data   // Oldest word.
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
    logic                    in_rdy;
    logic                    out_vld;
  } sdp_fifo_st_t;

  sdp_fifo_st_t s_r;
  sdp_fifo_st_t s_nxt;
  logic         push;
  logic         pop;

  ////////////////////////////////////////////////////////////////////////////
  // Flags are registered so that both handshake outputs come from flops.
  always_comb begin
    s_nxt = s_r;
    push  = in_valid && s_r.in_rdy;
    pop   = out_ready && s_r.out_vld;
    if (push) begin
      s_nxt.mem[s_r.wp] = in_data;
      s_nxt.wp = (s_r.wp == AW'(DEPTH - 1)) ? '0 : s_r.wp + 1'b1;
    end
    if (pop) begin
      s_nxt.rp = (s_r.rp == AW'(DEPTH - 1)) ? '0 : s_r.rp + 1'b1;
    end
    s_nxt.cnt     = s_r.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
    s_nxt.in_rdy  = s_nxt.cnt != (AW + 1)'(DEPTH);
    s_nxt.out_vld = s_nxt.cnt != '0;
  end

  // State register.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s_r        <= '0;
      s_r.in_rdy <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign in_ready  = s_r.in_rdy;
  assign out_valid = s_r.out_vld;
  assign out_data  = s_r.mem[s_r.rp];
endmodule

////////////////////////////////////////////////////////////////////////////////
module sdp_host import sdp_pkg::*; #(
  parameter int DQ_W  = 16,
  parameter int DEPTH = 8,
  parameter int NL    = (DQ_W == 16) ? 2 : 1
) (
  input  wire logic            core_clk,  // System clock.
  input  wire logic            sys_rst,   // Synchronous reset, active high.
  sdp_link_if.host             pins,      // Memory pins.
  input  wire logic            req_valid, // Access request.
  output logic                 req_ready, // Request taken when both high and low_power is low.
  input  wire logic            req_write, // One for write, zero for read.
  input  wire logic [1:0]      req_bank,  // Bank.
  input  wire logic [12:0]     req_row,   // Row.
  input  wire logic [11:0]     req_col,   // Column.
  input  wire logic [DQ_W-1:0] req_wdata, // Write data.
  input  wire logic [NL-1:0]   req_wmask, // Write lane masks, high drops a lane.
  input  wire logic            low_power, // Level asking for power-down.
  output logic                 init_done, // Mode word loaded.
  output logic                 rd_valid,  // Read word available.
  input  wire logic            rd_ready,  // Read word taken.
  output logic [DQ_W-1:0]      rd_data    // Read word.
);
  typedef struct packed {
    sdp_hstate_t     st;
    logic [3:0]      cnt;
    logic            wr;
    logic [11:0]     col;
    logic [DQ_W-1:0] wdata;
    logic [NL-1:0]   wmask;
    logic [3:0]      cmd;
    logic            cke;
    logic [1:0]      ba;
    logic [12:0]     addr;
    logic            lo;
    logic            hi;
    logic [DQ_W-1:0] dq;
    logic            dq_oe_n;
    logic            push;
    logic [DQ_W-1:0] pdata;
    logic            ready;
    logic            done;
  } sdp_host_st_t;

  sdp_host_st_t s_r;
  sdp_host_st_t s_nxt;
  logic         f_ready;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer; the device is deselected on every cycle without a command.
  always_comb begin
    s_nxt         = s_r;
    s_nxt.cmd     = {1'b1, SDP_CMD_BST[2:0] | 3'h7};
    s_nxt.cke     = 1'b1;
    s_nxt.dq_oe_n = 1'b1;
    s_nxt.lo      = 1'b0;
    s_nxt.hi      = 1'b0;
    s_nxt.push    = 1'b0;
    s_nxt.cnt     = s_r.cnt + 4'h1;
    unique case (s_r.st)
      SDP_H_INIT: begin
        if (s_r.cnt == SDP_INIT_CYC) begin
          s_nxt.cmd  = SDP_CMD_PRE;
          s_nxt.addr = '0;
          s_nxt.addr[SDP_PRE_ALL_BIT] = 1'b1;
          s_nxt.st   = SDP_H_MODE;
        end
      end
      SDP_H_MODE: begin
        s_nxt.cmd  = SDP_CMD_MODE;
        s_nxt.addr = SDP_HOST_MODE;
        s_nxt.cnt  = '0;
        s_nxt.st   = SDP_H_RECOV;
      end
      SDP_H_RECOV: begin
        if (s_r.cnt == SDP_RP_CYC) begin
          s_nxt.st   = SDP_H_IDLE;
          s_nxt.done = 1'b1;
        end
      end
      SDP_H_IDLE: begin
        if (low_power) begin
          s_nxt.cke = 1'b0;
          s_nxt.st  = SDP_H_PD;
        end else if (req_valid && s_r.ready) begin
          s_nxt.wr    = req_write;
          s_nxt.col   = req_col;
          s_nxt.wdata = req_wdata;
          s_nxt.wmask = req_wmask;
          s_nxt.cmd   = SDP_CMD_ACT;
          s_nxt.ba    = req_bank;
          s_nxt.addr  = req_row;
          s_nxt.cnt   = '0;
          s_nxt.st    = SDP_H_ACTW;
        end
      end
      SDP_H_PD: begin
        s_nxt.cke = low_power ? 1'b0 : 1'b1;
        if (!low_power) begin
          s_nxt.cnt = '0;
          s_nxt.st  = SDP_H_RECOV;
        end
      end
      SDP_H_ACTW: begin
        if (s_r.cnt == SDP_RCD_CYC - 4'h1) begin
          s_nxt.cmd  = s_r.wr ? SDP_CMD_WRITE : SDP_CMD_READ;
          s_nxt.addr = sdp_addr_of(s_r.col, DQ_W, 1'b1);
          s_nxt.cnt  = '0;
          s_nxt.st   = s_r.wr ? SDP_H_RECOV : SDP_H_RDW;
          if (s_r.wr) begin
            s_nxt.dq      = s_r.wdata;
            s_nxt.dq_oe_n = 1'b0;
            s_nxt.hi      = s_r.wmask[NL-1];
            s_nxt.lo      = (NL == 2) ? s_r.wmask[0] : 1'b0;
          end
        end
      end
      SDP_H_RDW: begin
        if (pins.dev_dq_oe_n == '0) begin
          s_nxt.push  = 1'b1;
          s_nxt.pdata = pins.dq;
          s_nxt.cnt   = '0;
          s_nxt.st    = SDP_H_RECOV;
        end else if (s_r.cnt == SDP_RD_TMO) begin
          s_nxt.cnt = '0;
          s_nxt.st  = SDP_H_RECOV;
        end
      end
      default: s_nxt.st = SDP_H_INIT;
    endcase
    // A request is only taken when the read word will have room.
    s_nxt.ready = (s_nxt.st == SDP_H_IDLE) && !low_power && f_ready && !s_nxt.push;
  end

  // State register.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s_r         <= '0;
      s_r.cmd     <= 4'hf;
      s_r.cke     <= 1'b1;
      s_r.dq_oe_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Read words wait here until the user takes them.
  sdp_fifo #(.W(DQ_W), .DEPTH(DEPTH)) u_rd_fifo (
    .core_clk  (core_clk),
    .sys_rst   (sys_rst),
    .in_valid  (s_r.push),
    .in_ready  (f_ready),
    .in_data   (s_r.pdata),
    .out_valid (rd_valid),
    .out_ready (rd_ready),
    .out_data  (rd_data)
  );

  assign pins.cke            = s_r.cke;
  assign pins.cs_n           = s_r.cmd[3];
  assign pins.ras_n          = s_r.cmd[2];
  assign pins.cas_n          = s_r.cmd[1];
  assign pins.we_n           = s_r.cmd[0];
  assign pins.ba             = s_r.ba;
  assign pins.addr           = s_r.addr;
  assign pins.low_byte_mask  = s_r.lo;
  assign pins.high_byte_mask = s_r.hi;
  assign pins.host_dq        = s_r.dq;
  assign pins.host_dq_oe_n   = s_r.dq_oe_n;
  assign req_ready           = s_r.ready;
  assign init_done           = s_r.done;
endmodule
`default_nettype wire

// file: sdp_dev.sv
`timescale 1ns/1ps
`default_nettype none
module sdp_dev import sdp_pkg::*; #(
  parameter int DQ_W = 16,
  parameter int NL   = (DQ_W == 16) ? 2 : 1
) (
  input  wire logic core_clk,         // System clock.
  input  wire logic sys_rst,          // Synchronous reset, active high.
  sdp_link_if.dev   pins,             // Memory pins.
  output logic      in_power_down,    // Precharge or active power-down.
  output logic      in_self_refresh,  // Self refresh.
  output logic      in_clock_suspend, // Burst frozen by clock enable.
  output logic [12:0] mode_code       // Last loaded mode word.
);
  localparam int LW    = DQ_W / NL;
  localparam int MCB   = SDP_MEM_COL_BITS;
  localparam int MEM_N = 4 << MCB;

  typedef struct packed {
    sdp_pmode_t                  pmode;
    logic                        cke_prev;
    logic [12:0]                 mode;
    logic [3:0]                  open;
    logic [3:0][12:0]            row;
    logic                        bact;
    logic                        bwr;
    logic                        bap;
    logic                        bfull;
    logic [1:0]                  bbank;
    logic [11:0]                 bcol;
    logic [3:0]                  brem;
    logic [1:0]                  pv;
    logic [1:0][DQ_W-1:0]        pd;
    logic [NL-1:0]               dqm_d;
    logic [DQ_W-1:0]             dq;
    logic [NL-1:0]               oe_n;
    logic [MEM_N-1:0][DQ_W-1:0]  mem;
    logic                        st_pd;
    logic                        st_sr;
    logic                        st_su;
  } sdp_dev_st_t;

  sdp_dev_st_t s_r;
  sdp_dev_st_t s_nxt;

  logic [3:0]     cmd;
  logic [NL-1:0]  lmask;
  logic           susp;
  logic           rw;
  logic           beat;
  logic           wr;
  logic           ap;
  logic           full;
  logic [1:0]     bk;
  logic [11:0]    col;
  logic [11:0]    bm;
  logic [3:0]     rem;
  logic [3:0]     bl;
  logic [2+MCB-1:0] idx;
  logic           sel;

  ////////////////////////////////////////////////////////////////////////////
  // Pin decode. Everything below is seen only through the clocked register,
  // so a pin counts only at a rising edge.
  always_comb begin
    cmd      = {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n};
    lmask    = '0;
    lmask[0] = (NL == 2) ? pins.low_byte_mask : pins.high_byte_mask;
    lmask[NL-1] = pins.high_byte_mask;
    unique case (s_r.mode[SDP_BL_LSB +: 3])
      3'h0:    bl = 4'h1;
      3'h1:    bl = 4'h2;
      3'h2:    bl = 4'h4;
      default: bl = 4'h8;
    endcase
    sel = s_r.mode[SDP_CL_LSB +: 3] == SDP_CL3;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state. Clock suspend looks at the enable of the previous edge,
  // while power-down exit looks at the pin as it is now, so the exit does
  // not wait for an extra registered sample.
  always_comb begin
    s_nxt          = s_r;
    s_nxt.cke_prev = pins.cke;
    rw   = 1'b0;
    beat = 1'b0;
    wr   = s_r.bwr;
    ap   = s_r.bap;
    full = s_r.bfull;
    bk   = s_r.bbank;
    col  = s_r.bcol;
    rem  = s_r.brem;
    bm   = '1;
    idx  = '0;
    susp = (s_r.pmode == SDP_RUN) && !s_r.cke_prev && (s_r.bact || (s_r.pv != '0));
    if (s_r.pmode != SDP_RUN) begin
      // Inputs other than clock enable are not looked at here.
      if (pins.cke) begin
        s_nxt.pmode = SDP_RUN;
      end
    end else if (susp) begin
      // Frozen: burst position and output registers hold.
      s_nxt.pmode = SDP_RUN;
    end else if (!pins.cke && !s_r.bact && (s_r.pv == '0)) begin
      // Entry needs an empty pipe so no read word is stranded.
      if (s_r.open != '0) begin
        s_nxt.pmode = SDP_PD_ACT;
      end else if (cmd == SDP_CMD_REFR) begin
        s_nxt.pmode = SDP_SELF;
      end else begin
        s_nxt.pmode = SDP_PD_PRE;
      end
    end else begin
      // Start or continue a burst; a new column command wins.
      rw = ((cmd == SDP_CMD_READ) || (cmd == SDP_CMD_WRITE)) && s_r.open[pins.ba];
      if (rw) begin
        beat = 1'b1;
        wr   = cmd == SDP_CMD_WRITE;
        bk   = pins.ba;
        col  = sdp_col_of(pins.addr, DQ_W);
        ap   = pins.addr[SDP_PRE_ALL_BIT];
        full = s_r.mode[SDP_BL_LSB +: 3] == SDP_BL_FULL;
        rem  = bl;
      end else if (s_r.bact && (cmd != SDP_CMD_BST)) begin
        beat = 1'b1;
      end else if (cmd == SDP_CMD_BST) begin
        s_nxt.bact = 1'b0;
      end
      if (!full) begin
        bm = {8'h00, bl - 4'h1};
      end
      s_nxt.pd[1] = s_r.pd[0];
      s_nxt.pv    = {s_r.pv[0], beat && !wr};
      if (beat) begin
        idx = {bk, col[MCB-1:0]};
        if (wr) begin
          for (int l = 0; l < NL; l++) begin
            if (!lmask[l]) begin
              s_nxt.mem[idx][l*LW +: LW] = pins.dq[l*LW +: LW];
            end
          end
        end else begin
          s_nxt.pd[0] = s_r.mem[idx];
        end
        s_nxt.bcol  = (col & ~bm) | ((col + 12'h001) & bm);
        s_nxt.brem  = rem - 4'h1;
        s_nxt.bact  = full || (rem != 4'h1);
        s_nxt.bwr   = wr;
        s_nxt.bap   = ap;
        s_nxt.bfull = full;
        s_nxt.bbank = bk;
        if (!s_nxt.bact && ap) begin
          s_nxt.open[bk] = 1'b0;
        end
      end
      // Masks are captured whether or not the device is selected.
      s_nxt.dqm_d = lmask;
      s_nxt.dq    = s_r.pd[sel];
      s_nxt.oe_n  = {NL{!s_r.pv[sel]}} | s_r.dqm_d;
      // Row and bank commands; select high leaves cmd above 4'h7.
      unique case (cmd)
        SDP_CMD_ACT: begin
          s_nxt.open[pins.ba] = 1'b1;
          s_nxt.row[pins.ba]  = pins.addr;
        end
        SDP_CMD_PRE: begin
          if (pins.addr[SDP_PRE_ALL_BIT]) begin
            s_nxt.open = '0;
          end else begin
            s_nxt.open[pins.ba] = 1'b0;
          end
          if (pins.addr[SDP_PRE_ALL_BIT] || (pins.ba == s_r.bbank)) begin
            s_nxt.bact = 1'b0;
          end
        end
        SDP_CMD_MODE: begin
          if (s_r.open == '0) begin
            s_nxt.mode = pins.addr;
          end
        end
        default: begin
        end
      endcase
    end
    s_nxt.st_pd = (s_nxt.pmode == SDP_PD_PRE) || (s_nxt.pmode == SDP_PD_ACT);
    s_nxt.st_sr = s_nxt.pmode == SDP_SELF;
    s_nxt.st_su = susp;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register. There is no reset pin on the part; sys_rst only gives
  // the model a defined start.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s_r          <= '0;
      s_r.cke_prev <= 1'b1;
      s_r.mode     <= SDP_MODE_RST;
      s_r.oe_n     <= '1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs come straight from the register.
  assign pins.dev_dq      = s_r.dq;
  assign pins.dev_dq_oe_n = s_r.oe_n;
  assign in_power_down    = s_r.st_pd;
  assign in_self_refresh  = s_r.st_sr;
  assign in_clock_suspend = s_r.st_su;
  assign mode_code        = s_r.mode;
endmodule
`default_nettype wire

// file: sdp_link_props.sv
`timescale 1ns/1ps
`default_nettype none
module sdp_link_props import sdp_pkg::*; #(
  parameter int NL = 2
) (
  input wire logic          core_clk,       // System clock.
  input wire logic          sys_rst,        // Synchronous reset.
  input wire logic          cke,            // Clock enable.
  input wire logic          cs_n,           // Select, low active.
  input wire logic          ras_n,          // Row strobe.
  input wire logic          cas_n,          // Column strobe.
  input wire logic          we_n,           // Write strobe.
  input wire logic [1:0]    ba,             // Bank.
  input wire logic [12:0]   addr,           // Address.
  input wire logic          low_byte_mask,  // Low lane mask.
  input wire logic          high_byte_mask, // High lane mask.
  input wire logic          host_dq_oe_n,   // Host drives bus when low.
  input wire logic [NL-1:0] dev_dq_oe_n     // Device lane drive when low.
);
  logic [3:0] cmd;

  // Command word as the device decodes it.
  assign cmd = {cs_n, ras_n, cas_n, we_n};

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // Pins must be quiet the moment reset lets go, before any init command.
  chk_reset_quiet: assert property ($fell(sys_rst) |->
    cs_n && cke && host_dq_oe_n && &dev_dq_oe_n)
    else $error("pins not quiet after reset");
  chk_no_contention: assert property (!host_dq_oe_n |-> &dev_dq_oe_n)
    else $error("both ends drive the data bus");
  chk_read_latency: assert property (
    cmd == SDP_CMD_READ && !low_byte_mask && !high_byte_mask |-> ##2 dev_dq_oe_n == '0)
    else $error("read data not driven two edges after read");
  chk_act_then_rw: assert property (cmd == SDP_CMD_ACT |-> ##2
    ((cmd == SDP_CMD_READ || cmd == SDP_CMD_WRITE) && ba == $past(ba, 2)))
    else $error("activate not followed by access to same bank");
  chk_auto_pre: assert property ((cmd == SDP_CMD_READ || cmd == SDP_CMD_WRITE) |->
    addr[SDP_PRE_ALL_BIT])
    else $error("access without auto precharge bit");
  chk_write_drive: assert property (cmd == SDP_CMD_WRITE |->
    !host_dq_oe_n ##1 host_dq_oe_n)
    else $error("write data not driven for exactly one beat");
  chk_mode_word: assert property (cmd == SDP_CMD_MODE |-> addr == SDP_HOST_MODE)
    else $error("mode word on address bus wrong");
  chk_pre_all: assert property (cmd == SDP_CMD_PRE |-> addr[SDP_PRE_ALL_BIT])
    else $error("init precharge does not close all banks");
  chk_cke_quiet: assert property (!cke |-> cs_n)
    else $error("command issued while clock disabled");
endmodule
`default_nettype wire

// file: sdp_pin_interface_bench.sv
`timescale 1ns/1ps
`default_nettype none
module sdram_pin_interface_bench import sdp_pkg::*;;
  typedef struct packed {
    logic        wr;
    logic [1:0]  bank;
    logic [11:0] col;
    logic [15:0] data;
    logic [1:0]  mask;
  } sdp_row_t;

  logic core_clk, sys_rst, req_valid, req_ready, req_write, low_power, init_done;
  logic rd_valid, rd_ready, in_power_down, in_self_refresh, in_clock_suspend;
  logic [1:0] req_bank, req_wmask;
  logic [12:0] req_row, mode_code;
  logic [11:0] req_col;
  logic [15:0] req_wdata, rd_data;
  int failures, compares, n;
  // Writes with lane masks first, then reads whose data follows from the masks.
  sdp_row_t rows [10] = '{'{1, 0, 0, 16'h1234, 0}, '{1, 1, 1, 16'habcd, 0},
    '{1, 0, 0, 16'hff00, 1}, '{1, 1, 1, 16'h5566, 2}, '{1, 3, 12'h3ff, 16'h0f0f, 0},
    '{1, 2, 2, 16'h1111, 0}, '{1, 2, 2, 16'h9876, 3}, '{0, 0, 0, 16'hff34, 0},
    '{0, 1, 1, 16'hab66, 0}, '{0, 2, 2, 16'h1111, 0}};

  sdp_link_if #(.DQ_W(16)) u_sdp_link_if ();
  sdp_host #(.DQ_W(16), .DEPTH(8)) u_sdp_host (.core_clk, .sys_rst, .pins(u_sdp_link_if),
    .req_valid, .req_ready, .req_write, .req_bank, .req_row, .req_col, .req_wdata,
    .req_wmask, .low_power, .init_done, .rd_valid, .rd_ready, .rd_data);
  sdp_dev #(.DQ_W(16)) u_sdp_dev (.core_clk, .sys_rst, .pins(u_sdp_link_if), .in_power_down,
    .in_self_refresh, .in_clock_suspend, .mode_code);
  sdp_link_props #(.NL(2)) u_sdp_link_props (.core_clk, .sys_rst, .cke(u_sdp_link_if.cke),
    .cs_n(u_sdp_link_if.cs_n), .ras_n(u_sdp_link_if.ras_n), .cas_n(u_sdp_link_if.cas_n),
    .we_n(u_sdp_link_if.we_n), .ba(u_sdp_link_if.ba), .addr(u_sdp_link_if.addr),
    .low_byte_mask(u_sdp_link_if.low_byte_mask), .high_byte_mask(u_sdp_link_if.high_byte_mask),
    .host_dq_oe_n(u_sdp_link_if.host_dq_oe_n), .dev_dq_oe_n(u_sdp_link_if.dev_dq_oe_n));

  ////////////////////////////////////////////////////////////////////////////////
  // Free running 40 MHz clock.
  always #12.5 core_clk = ~core_clk;

  task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task final_report;
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Request is held until the edge that samples req_ready high.
  task issue(input sdp_row_t r);
    @(posedge core_clk);
    req_valid <= 1;
    req_write <= r.wr;
    req_bank <= r.bank;
    req_row <= {r.bank, 11'h5a5};
    req_col <= r.col;
    req_wdata <= r.data;
    req_wmask <= r.mask;
    n = 0;
    do begin @(posedge core_clk); n++; end while (req_ready !== 1'b1 && n < 200);
    req_valid <= 0;
    check("take", 16'(n < 200), 16'h1);
  endtask

  // The word is read at the same edge that pops it.
  task get_read(input logic [15:0] exp);
    n = 0;
    do begin @(posedge core_clk); n++; end while (rd_valid !== 1'b1 && n < 200);
    check("rd_data", rd_data, exp);
  endtask

  task wait_init;
    n = 0;
    do begin @(posedge core_clk); n++; end while (init_done !== 1'b1 && n < 200);
    check("mode_code", mode_code, 16'(SDP_HOST_MODE));
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // A full run is well under a thousand cycles, so this only cuts a hang.
  initial begin
    #(25 * 5000);
    failures++;
    final_report;
  end

  // Main sequence: reset, table of accesses, then full buffer, power-down, reset again.
  initial begin
    {core_clk, req_valid, req_write, req_bank, req_row, req_col} = '0;
    {req_wdata, req_wmask, low_power, failures, compares} = '0;
    sys_rst = 1;
    rd_ready = 1;
    repeat (8) @(posedge core_clk);
    sys_rst <= 0;
    @(posedge core_clk);
    check("cs_n", u_sdp_link_if.cs_n, 16'h1);
    check("req_ready", req_ready, 16'h0);
    wait_init;
    for (int i = 0; i < 10; i++) begin
      issue(rows[i]);
      if (!rows[i].wr) get_read(rows[i].data);
    end
    // Reader stalls: eight words fill the buffer and further requests are refused.
    rd_ready <= 0;
    for (int i = 0; i < 8; i++) issue(rows[7 + i % 3]);
    repeat (30) @(posedge core_clk);
    check("full_refuse", req_ready, 16'h0);
    rd_ready <= 1;
    for (int i = 0; i < 8; i++) get_read(rows[7 + i % 3].data);
    repeat (4) @(posedge core_clk);
    check("empty", rd_valid, 16'h0);
    // Power-down with all banks closed, then an access after the exit.
    low_power <= 1;
    repeat (20) @(posedge core_clk);
    check("pd", in_power_down, 16'h1);
    check("self", in_self_refresh, 16'h0);
    check("susp", in_clock_suspend, 16'h0);
    check("cke", u_sdp_link_if.cke, 16'h0);
    low_power <= 0;
    repeat (20) @(posedge core_clk);
    check("pd_exit", in_power_down, 16'h0);
    issue(rows[8]);
    get_read(rows[8].data);
    // Reset in mid-run clears the mode word until the host loads it again.
    sys_rst <= 1;
    repeat (2) @(posedge core_clk);
    check("mode_rst", mode_code, 16'(SDP_MODE_RST));
    sys_rst <= 0;
    wait_init;
    final_report;
  end
endmodule
`default_nettype wire
